// ### src/ifm_pkg.sv
// Purpose: Constants for the interrupt flag and mask unit
// Assumes: 4-bit RAM words, 6-bit RAM address for the reserved locations
// Notes:   Flag index order doubles as the source numbering used everywhere
package ifm_pkg;
    // Reserved RAM word addresses
    localparam logic [5:0] ADDR_CTRL0    = 6'h00;
    localparam logic [5:0] ADDR_CTRL1    = 6'h01;
    localparam logic [5:0] ADDR_TIMER_BC = 6'h02;
    localparam logic [5:0] ADDR_TIMER_DA = 6'h03;
    localparam logic [5:0] ADDR_EXT_HI   = 6'h22;
    localparam logic [5:0] ADDR_SERIAL   = 6'h23;
    localparam logic [5:0] ADDR_EDGE_A   = 6'h26;
    localparam logic [5:0] ADDR_EDGE_B   = 6'h27;

    // Bit positions inside the words
    localparam int BIT_ALLOW = 0;
    localparam int BIT_FLAG_LO  = 0;
    localparam int BIT_BLOCK_LO = 1;
    localparam int BIT_FLAG_HI  = 2;
    localparam int BIT_BLOCK_HI = 3;

    // Source indices into flag and block vectors
    localparam int SRC_EXT0 = 0;
    localparam int SRC_EXT1 = 1;
    localparam int SRC_EXT2 = 2;
    localparam int SRC_EXT3 = 3;
    localparam int SRC_TA   = 4;
    localparam int SRC_TB   = 5;
    localparam int SRC_TC   = 6;
    localparam int SRC_TD   = 7;
    localparam int SRC_SER  = 8;
    localparam int SRC_ADC  = 9;
    localparam int NUM_SRC  = 10;
    localparam int NUM_VEC  = 7;

    // Synchronised pins: four external inputs and the capture pin
    localparam int NUM_PIN  = 5;
    localparam int PIN_CAP  = 4;

    // Reset values
    localparam logic [NUM_SRC-1:0] RST_FLAGS  = 10'h000;
    localparam logic [NUM_SRC-1:0] RST_BLOCKS = 10'h3FF;
    localparam logic               RST_ALLOW  = 1'b0;
    localparam logic [3:0]         RST_EDGE_A = 4'h0;
    localparam logic [3:0]         RST_EDGE_B = 4'h0;

    // Vector addresses, highest priority first, step of two
    localparam logic [15:0] VEC_BASE = 16'h0002;
    localparam logic [15:0] VEC_STEP = 16'h0002;
    localparam logic [15:0] VEC_LAST = 16'h000E;

    // Edge selector codes
    localparam logic [1:0] EDGE_NONE = 2'b00;
    localparam logic [1:0] EDGE_FALL = 2'b01;
    localparam logic [1:0] EDGE_RISE = 2'b10;
    localparam logic [1:0] EDGE_BOTH = 2'b11;

    typedef enum {IFM_IDLE, IFM_FINISH, IFM_PUSH, IFM_JUMP} ifm_phase_e;
endpackage

// ### src/ifm_irq_unit.sv
// Purpose: Interrupt flags, masks, edge selection and vector sequencing
// Assumes: CPU reads and writes whole 4-bit words, read data one cycle later
// Notes:   Pins pass a three-stage synchroniser; peripheral events are pulses
//
// Overview of operation
// [RL1] Global allow bit enables servicing; cleared on acceptance, set by return.
// [RL2] External inputs 0 and 1 flag on falling pin transitions.
// [RL3] External inputs 2 and 3 flag on their selected pin edge.
// [RL4] Two write-only edge select registers sit at 0x26 and 0x27.
// [RL5] Two-bit selector: 00 none, 01 falling, 10 rising, 11 both.
// [RL6] External mask bit 0 passes its request, 1 suppresses it.
// [RL7] Timer A overflow sets the timer A flag in bit 2.
// [RL8] Timer A mask in bit 3 suppresses its request when 1.
// [RL9] Timer B overflow sets the timer B flag in bit 0.
// [RL10] Timer B mask in bit 1 blocks its request when 1.
// [RL11] Timer C overflow sets the timer C flag in bit 2.
// [RL12] Timer C mask in bit 3 blocks its request when 1.
// [RL13] Timer D flag set on overflow or selected capture pin edge.
// [RL14] Timer D mask in bit 1 blocks its request when 1.
// [RL15] Serial flag set on transfer completion or suspension.
// [RL16] Serial mask in bit 3 blocks its request when 1.
// [RL17] Conversion done sets the converter flag in bit 2.
// [RL18] Converter mask in bit 3 blocks its request when 1.
// [RL19] Highest priority unmasked flagged source wins; lower ones are ignored. Here lower ones stay flagged and are accepted after the return.
// [RL20] Request means flag 1 and mask 0; serviced only while allowed.
// [RL21] Fixed priority, vectors 0x0002 to 0x000E in steps of two.
// [RL22] Software cannot set flags; reset clears flags and allow, sets masks.
// [RL23] Cycle one finishes, two clears allow, two and three push, three jumps.
// [RL24] An event coinciding with a software clear leaves the flag set.
`timescale 1ns/1ps

module ifm_irq_unit
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [5:0]  ramAddr,
    input  wire logic        ramWrite,
    input  wire logic [3:0]  ramWriteData,
    output logic      [3:0]  ramReadData,
    input  wire logic        extIrqPin0N,
    input  wire logic        extIrqPin1N,
    input  wire logic        extIrqPin2,
    input  wire logic        extIrqPin3,
    input  wire logic        captureEventPinD,
    input  wire logic        captureEnable,
    input  wire logic        timerAOverflow,
    input  wire logic        timerBOverflow,
    input  wire logic        timerCOverflow,
    input  wire logic        timerDOverflow,
    input  wire logic        serialDone,
    input  wire logic        serialSuspend,
    input  wire logic        conversionDone,
    input  wire logic        returnFromIrqInstr,
    output logic             globalIrqAllow,
    output logic             irqRequest,
    output logic             irqAccept,
    output logic             stackPush,
    output logic             vectorJump,
    output logic      [15:0] vectorAddr
);
    typedef struct packed {
        logic [ifm_pkg::NUM_PIN-1:0] sync1;
        logic [ifm_pkg::NUM_PIN-1:0] sync2;
        logic [ifm_pkg::NUM_PIN-1:0] sync3;
        logic [ifm_pkg::NUM_PIN-1:0] level;
        logic [ifm_pkg::NUM_SRC-1:0] flag;
        logic [ifm_pkg::NUM_SRC-1:0] block;
        logic                        allow;
        logic [3:0]                  edgeA;
        logic [3:0]                  edgeB;
        ifm_pkg::ifm_phase_e         phase;
        logic [15:0]                 vec;
        logic [3:0]                  rd;
        logic                        request;
        logic                        accept;
        logic                        push;
        logic                        jump;
    } ifm_state_s;

    ifm_state_s st;
    ifm_state_s next_st;

    // Edge match against a two-bit selector
    function automatic logic edgeHit(input logic [1:0] sel, input logic prev, input logic cur);
        logic fall;
        logic rise;
        fall = prev & ~cur;
        rise = ~prev & cur;
        edgeHit = (sel[0] & fall) | (sel[1] & rise); // see [RL5]
    endfunction

    // Software write may only clear a flag; an event always wins
    function automatic logic flagNext(input logic old, input logic wr, input logic wbit,
                                      input logic ev);
        flagNext = ev | (old & ~(wr & ~wbit)); // see [RL22] see [RL24]
    endfunction

    // Vector of the first group asserted, lower index means higher priority
    function automatic logic [15:0] pickVector(input logic [ifm_pkg::NUM_VEC-1:0] grp);
        logic [15:0] v;
        v = ifm_pkg::VEC_LAST;
        for (int i = ifm_pkg::NUM_VEC - 1; i >= 0; i--)
        begin
            if (grp[i])
            begin
                v = ifm_pkg::VEC_BASE + 16'(i) * ifm_pkg::VEC_STEP; // see [RL21]
            end
        end
        pickVector = v; // see [RL19]
    endfunction

    logic [ifm_pkg::NUM_PIN-1:0] pinRaw;
    logic [ifm_pkg::NUM_PIN-1:0] pinLevel;
    logic [ifm_pkg::NUM_SRC-1:0] evt;
    logic [ifm_pkg::NUM_SRC-1:0] req;
    logic [ifm_pkg::NUM_VEC-1:0] grp;
    logic [ifm_pkg::NUM_SRC-1:0] wrHit;
    logic [ifm_pkg::NUM_SRC-1:0] wrBit;

    assign pinRaw = {captureEventPinD, extIrqPin3, extIrqPin2, extIrqPin1N, extIrqPin0N};

    // Filtered pin level: a change counts once stages two and three agree
    always_comb
    begin
        for (int i = 0; i < ifm_pkg::NUM_PIN; i++)
        begin
            pinLevel[i] = (st.sync2[i] == st.sync3[i]) ? st.sync3[i] : st.level[i];
        end
    end

    // Source events; the active-low inputs fire on their falling edge
    always_comb
    begin
        evt                   = '0;
        evt[ifm_pkg::SRC_EXT0] = edgeHit(ifm_pkg::EDGE_FALL, st.level[0], pinLevel[0]); // see [RL2]
        evt[ifm_pkg::SRC_EXT1] = edgeHit(ifm_pkg::EDGE_FALL, st.level[1], pinLevel[1]); // see [RL2]
        evt[ifm_pkg::SRC_EXT2] = edgeHit(st.edgeA[1:0], st.level[2], pinLevel[2]); // see [RL3]
        evt[ifm_pkg::SRC_EXT3] = edgeHit(st.edgeA[3:2], st.level[3], pinLevel[3]); // see [RL3]
        evt[ifm_pkg::SRC_TA]   = timerAOverflow; // see [RL7]
        evt[ifm_pkg::SRC_TB]   = timerBOverflow; // see [RL9]
        evt[ifm_pkg::SRC_TC]   = timerCOverflow; // see [RL11]
        // Capture edge only counts while timer D runs in capture mode
        evt[ifm_pkg::SRC_TD]   = timerDOverflow | (captureEnable
                               & edgeHit(st.edgeB[1:0], st.level[ifm_pkg::PIN_CAP],
                                         pinLevel[ifm_pkg::PIN_CAP])); // see [RL13]
        evt[ifm_pkg::SRC_SER]  = serialDone | serialSuspend; // see [RL15]
        evt[ifm_pkg::SRC_ADC]  = conversionDone; // see [RL17]
    end

    // Request per source, then grouped onto the seven shared vectors
    always_comb
    begin
        req    = st.flag & ~st.block; // see [RL6] see [RL8] see [RL10] see [RL12] see [RL20]
        grp[0] = req[ifm_pkg::SRC_EXT0];
        grp[1] = req[ifm_pkg::SRC_EXT1];
        grp[2] = req[ifm_pkg::SRC_TA];
        grp[3] = req[ifm_pkg::SRC_TB] | req[ifm_pkg::SRC_EXT2];
        grp[4] = req[ifm_pkg::SRC_TC] | req[ifm_pkg::SRC_EXT3];
        grp[5] = req[ifm_pkg::SRC_TD]; // see [RL14]
        grp[6] = req[ifm_pkg::SRC_SER] | req[ifm_pkg::SRC_ADC]; // see [RL16] see [RL18]
    end

    // Which flag bits the current write touches
    always_comb
    begin
        wrHit = '0;
        wrBit = '0;
        if (ramWrite && ramAddr == ifm_pkg::ADDR_CTRL0)
        begin
            wrHit[ifm_pkg::SRC_EXT0] = 1'b1;
            wrBit[ifm_pkg::SRC_EXT0] = ramWriteData[ifm_pkg::BIT_FLAG_HI];
        end
        else if (ramWrite && ramAddr == ifm_pkg::ADDR_CTRL1)
        begin
            wrHit[ifm_pkg::SRC_EXT1] = 1'b1;
            wrBit[ifm_pkg::SRC_EXT1] = ramWriteData[ifm_pkg::BIT_FLAG_LO];
            wrHit[ifm_pkg::SRC_TA]   = 1'b1;
            wrBit[ifm_pkg::SRC_TA]   = ramWriteData[ifm_pkg::BIT_FLAG_HI];
        end
        else if (ramWrite && ramAddr == ifm_pkg::ADDR_TIMER_BC)
        begin
            wrHit[ifm_pkg::SRC_TB] = 1'b1;
            wrBit[ifm_pkg::SRC_TB] = ramWriteData[ifm_pkg::BIT_FLAG_LO];
            wrHit[ifm_pkg::SRC_TC] = 1'b1;
            wrBit[ifm_pkg::SRC_TC] = ramWriteData[ifm_pkg::BIT_FLAG_HI];
        end
        else if (ramWrite && ramAddr == ifm_pkg::ADDR_TIMER_DA)
        begin
            wrHit[ifm_pkg::SRC_TD]  = 1'b1;
            wrBit[ifm_pkg::SRC_TD]  = ramWriteData[ifm_pkg::BIT_FLAG_LO];
            wrHit[ifm_pkg::SRC_ADC] = 1'b1;
            wrBit[ifm_pkg::SRC_ADC] = ramWriteData[ifm_pkg::BIT_FLAG_HI];
        end
        else if (ramWrite && ramAddr == ifm_pkg::ADDR_EXT_HI)
        begin
            wrHit[ifm_pkg::SRC_EXT2] = 1'b1;
            wrBit[ifm_pkg::SRC_EXT2] = ramWriteData[ifm_pkg::BIT_FLAG_LO];
            wrHit[ifm_pkg::SRC_EXT3] = 1'b1;
            wrBit[ifm_pkg::SRC_EXT3] = ramWriteData[ifm_pkg::BIT_FLAG_HI];
        end
        else if (ramWrite && ramAddr == ifm_pkg::ADDR_SERIAL)
        begin
            wrHit[ifm_pkg::SRC_SER] = 1'b1;
            wrBit[ifm_pkg::SRC_SER] = ramWriteData[ifm_pkg::BIT_FLAG_HI];
        end
    end

    // Next state: synchroniser, flags, masks, edge selects, sequencer, read port
    always_comb
    begin
        next_st       = st;
        next_st.sync1 = pinRaw;
        next_st.sync2 = st.sync1;
        next_st.sync3 = st.sync2;
        next_st.level = pinLevel;
        for (int i = 0; i < ifm_pkg::NUM_SRC; i++)
        begin
            next_st.flag[i] = flagNext(st.flag[i], wrHit[i], wrBit[i], evt[i]);
        end

        // Mask bits are plain read-write storage; the allow bit is also cleared by acceptance and set by return
        if (ramWrite && ramAddr == ifm_pkg::ADDR_CTRL0)
        begin
            next_st.allow                  = ramWriteData[ifm_pkg::BIT_ALLOW];
            next_st.block[ifm_pkg::SRC_EXT0] = ramWriteData[ifm_pkg::BIT_BLOCK_HI];
        end
        else if (ramWrite && ramAddr == ifm_pkg::ADDR_CTRL1)
        begin
            next_st.block[ifm_pkg::SRC_EXT1] = ramWriteData[ifm_pkg::BIT_BLOCK_LO];
            next_st.block[ifm_pkg::SRC_TA]   = ramWriteData[ifm_pkg::BIT_BLOCK_HI]; // see [RL8]
        end
        else if (ramWrite && ramAddr == ifm_pkg::ADDR_TIMER_BC)
        begin
            next_st.block[ifm_pkg::SRC_TB] = ramWriteData[ifm_pkg::BIT_BLOCK_LO]; // see [RL10]
            next_st.block[ifm_pkg::SRC_TC] = ramWriteData[ifm_pkg::BIT_BLOCK_HI]; // see [RL12]
        end
        else if (ramWrite && ramAddr == ifm_pkg::ADDR_TIMER_DA)
        begin
            next_st.block[ifm_pkg::SRC_TD]  = ramWriteData[ifm_pkg::BIT_BLOCK_LO]; // see [RL14]
            next_st.block[ifm_pkg::SRC_ADC] = ramWriteData[ifm_pkg::BIT_BLOCK_HI]; // see [RL18]
        end
        else if (ramWrite && ramAddr == ifm_pkg::ADDR_EXT_HI)
        begin
            next_st.block[ifm_pkg::SRC_EXT2] = ramWriteData[ifm_pkg::BIT_BLOCK_LO]; // see [RL6]
            next_st.block[ifm_pkg::SRC_EXT3] = ramWriteData[ifm_pkg::BIT_BLOCK_HI]; // see [RL6]
        end
        else if (ramWrite && ramAddr == ifm_pkg::ADDR_SERIAL)
        begin
            next_st.block[ifm_pkg::SRC_SER] = ramWriteData[ifm_pkg::BIT_BLOCK_HI]; // see [RL16]
        end
        else if (ramWrite && ramAddr == ifm_pkg::ADDR_EDGE_A)
        begin
            next_st.edgeA = ramWriteData; // see [RL4]
        end
        else if (ramWrite && ramAddr == ifm_pkg::ADDR_EDGE_B)
        begin
            next_st.edgeB = ramWriteData; // see [RL4]
        end

        // Acceptance sequence; vector frozen at acceptance so late flags cannot steer it
        next_st.accept = 1'b0;
        next_st.push   = 1'b0;
        next_st.jump   = 1'b0;
        case (st.phase)
            ifm_pkg::IFM_IDLE:
            begin
                if (st.allow && (|grp)) // see [RL1] see [RL20]
                begin
                    next_st.phase  = ifm_pkg::IFM_FINISH;
                    next_st.accept = 1'b1;
                    next_st.vec    = pickVector(grp); // see [RL19]
                end
            end
            ifm_pkg::IFM_FINISH:
            begin
                next_st.phase = ifm_pkg::IFM_PUSH;
                next_st.allow = 1'b0; // see [RL1] see [RL23]
                next_st.push  = 1'b1;
            end
            ifm_pkg::IFM_PUSH:
            begin
                next_st.phase = ifm_pkg::IFM_JUMP;
                next_st.push  = 1'b1; // see [RL23]
                next_st.jump  = 1'b1;
            end
            default:
            begin
                next_st.phase = ifm_pkg::IFM_IDLE;
            end
        endcase

        // Return instruction restores servicing; it wins over any clear
        if (returnFromIrqInstr)
        begin
            next_st.allow = 1'b1; // see [RL1]
        end

        // Pending request ignores the allow bit so software can poll it
        next_st.request = |(next_st.flag & ~next_st.block); // see [RL20]

        // Registered read port; edge selects are write-only and read zero
        next_st.rd = 4'h0;
        if (ramAddr == ifm_pkg::ADDR_CTRL0)
        begin
            next_st.rd = {st.block[0], st.flag[0], 1'b0, st.allow};
        end
        else if (ramAddr == ifm_pkg::ADDR_CTRL1)
        begin
            next_st.rd = {st.block[4], st.flag[4], st.block[1], st.flag[1]};
        end
        else if (ramAddr == ifm_pkg::ADDR_TIMER_BC)
        begin
            next_st.rd = {st.block[6], st.flag[6], st.block[5], st.flag[5]};
        end
        else if (ramAddr == ifm_pkg::ADDR_TIMER_DA)
        begin
            next_st.rd = {st.block[9], st.flag[9], st.block[7], st.flag[7]};
        end
        else if (ramAddr == ifm_pkg::ADDR_EXT_HI)
        begin
            next_st.rd = {st.block[3], st.flag[3], st.block[2], st.flag[2]};
        end
        else if (ramAddr == ifm_pkg::ADDR_SERIAL)
        begin
            next_st.rd = {st.block[8], st.flag[8], 2'b00};
        end
    end

    // State register; synchroniser stages reset high to match idle pins
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st         <= '0;
            st.sync1   <= '1;
            st.sync2   <= '1;
            st.sync3   <= '1;
            st.level   <= '1;
            st.flag    <= ifm_pkg::RST_FLAGS; // see [RL22]
            st.block   <= ifm_pkg::RST_BLOCKS; // see [RL22]
            st.allow   <= ifm_pkg::RST_ALLOW; // see [RL22]
            st.edgeA   <= ifm_pkg::RST_EDGE_A;
            st.edgeB   <= ifm_pkg::RST_EDGE_B;
            st.phase   <= ifm_pkg::IFM_IDLE;
            st.vec     <= ifm_pkg::VEC_BASE;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign ramReadData    = st.rd;
    assign globalIrqAllow = st.allow;
    assign irqRequest     = st.request;
    assign irqAccept      = st.accept;
    assign stackPush      = st.push;
    assign vectorJump     = st.jump;
    assign vectorAddr     = st.vec;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence s_push_first;
        stackPush && !vectorJump && !globalIrqAllow;
    endsequence
    sequence s_push_jump;
        stackPush && vectorJump;
    endsequence

    a_accept_seq_steps: assert property (irqAccept |=> s_push_first ##1 s_push_jump) // see [RL23]
        else $error("acceptance sequence out of step");
    a_accept_needs_allow: assert property (irqAccept |-> $past(st.allow) && $past(|grp)) // see [RL20]
        else $error("accepted without allow or request");
    a_no_accept_blocked: assert property (!st.allow |=> !irqAccept) // see [RL1]
        else $error("accepted while allow clear");
    a_return_sets_allow: assert property (returnFromIrqInstr |=> globalIrqAllow) // see [RL1]
        else $error("return did not restore allow");
    a_ext0_top_vector: assert property (irqAccept && $past(grp[0]) |-> vectorAddr == 16'h0002) // see [RL21]
        else $error("ext0 did not take first vector");
    a_low_ignored: assert property (irqAccept && $past(grp[5:0] == 6'h00)
                                    |-> vectorAddr == 16'h000E) // see [RL19]
        else $error("lowest vector wrong");
    a_set_beats_clear: assert property (evt[ifm_pkg::SRC_TA] |=> st.flag[ifm_pkg::SRC_TA]) // see [RL24]
        else $error("timer A event lost");
    a_no_soft_set: assert property ($rose(st.flag[ifm_pkg::SRC_EXT0])
                                    |-> $past(evt[ifm_pkg::SRC_EXT0])) // see [RL22]
        else $error("flag set without event");
    a_mask_suppress: assert property (st.block[ifm_pkg::SRC_TB] && st.block[ifm_pkg::SRC_EXT2]
                                      |-> !grp[3]) // see [RL10]
        else $error("masked timer B group requests");
    a_read_timer_a: assert property (ramAddr == ifm_pkg::ADDR_CTRL1
                                     |=> ramReadData[2] == $past(st.flag[ifm_pkg::SRC_TA])) // see [RL7]
        else $error("timer A flag read wrong");
endmodule

// ### verif/ifm_cpu_model.sv
// Purpose: CPU side of the interrupt unit: runs a service routine per vector
// Assumes: The bench clears the serviced flag while the routine runs
// Notes:   Return pulse comes a fixed span after the vector jump
`timescale 1ns/1ps

module ifm_cpu_model
#(
    parameter int SERVICE_CYCLES = 12
)
(
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic vectorJump,
    output logic      returnFromIrqInstr
);
    logic [7:0] count;
    logic       busy;

    // Routine starts at the jump and ends with one return pulse
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count              <= 8'h00;
            busy               <= 1'b0;
            returnFromIrqInstr <= 1'b0;
        end
        else
        begin
            returnFromIrqInstr <= 1'b0;
            if (vectorJump)
            begin
                busy  <= 1'b1;
                count <= 8'h00;
            end
            else if (busy)
            begin
                count <= count + 8'h01;
                if (count == 8'(SERVICE_CYCLES))
                begin
                    busy               <= 1'b0;
                    returnFromIrqInstr <= 1'b1;
                end
            end
        end
    end
endmodule

// ### verif/tb_top.sv
// Purpose: Self-checking bench for the interrupt flag and mask unit
// Assumes: Reads answer one cycle after the address; inputs move on falling edges
// Notes:   Capture pin, ext1 and ext3 pins stay constant
`timescale 1ns/1ps

module tb_top;
    typedef struct packed {
        logic [5:0]  a;
        logic [3:0]  un;
        logic [3:0]  fl;
        logic [3:0]  rs;
        logic [2:0]  e;
        logic [15:0] v;
    } ifm_row_s;

    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [5:0]  ramAddr = 6'h00;
    logic        ramWrite = 1'b0;
    logic [3:0]  ramWriteData = 4'h0;
    logic [3:0]  ramReadData;
    logic        pin0N = 1'b1;
    logic        pin2 = 1'b0;
    logic [6:0]  ev = 7'h00;
    logic        rtn;
    logic        globalIrqAllow, irqRequest, irqAccept, stackPush, vectorJump;
    logic [15:0] vectorAddr;
    int          bad_count = 0;
    int          comparisons = 0;
    ifm_row_s    rows [7] = '{'{6'h01, 4'h2, 4'h6, 4'hA, 3'd0, 16'h0006},
        '{6'h02, 4'h8, 4'h9, 4'hA, 3'd1, 16'h0008}, '{6'h02, 4'h2, 4'h6, 4'hA, 3'd2, 16'h000A},
        '{6'h03, 4'h8, 4'h9, 4'hA, 3'd3, 16'h000C}, '{6'h23, 4'h0, 4'h4, 4'h8, 3'd4, 16'h000E},
        '{6'h03, 4'h2, 4'h6, 4'hA, 3'd5, 16'h000E}, '{6'h23, 4'h0, 4'h4, 4'h8, 3'd6, 16'h000E}};
    logic [9:0]  rst [8] = '{10'h008, 10'h01A, 10'h02A, 10'h03A, 10'h22A, 10'h238, 10'h260,
        10'h100};

    ifm_irq_unit DUT (.clk_sys(clk_sys), .reset_n(reset_n), .ramAddr(ramAddr),
        .ramWrite(ramWrite), .ramWriteData(ramWriteData), .ramReadData(ramReadData),
        .extIrqPin0N(pin0N), .extIrqPin1N(1'b1), .extIrqPin2(pin2), .extIrqPin3(1'b0),
        .captureEventPinD(1'b0), .captureEnable(1'b0), .timerAOverflow(ev[0]),
        .timerBOverflow(ev[1]), .timerCOverflow(ev[2]), .timerDOverflow(ev[3]),
        .serialDone(ev[4]), .serialSuspend(ev[6]), .conversionDone(ev[5]),
        .returnFromIrqInstr(rtn), .globalIrqAllow(globalIrqAllow), .irqRequest(irqRequest),
        .irqAccept(irqAccept), .stackPush(stackPush), .vectorJump(vectorJump),
        .vectorAddr(vectorAddr));
    ifm_cpu_model #(.SERVICE_CYCLES(12)) cpu (.clk_sys(clk_sys), .reset_n(reset_n),
        .vectorJump(vectorJump), .returnFromIrqInstr(rtn));

    // Free-running 40 MHz clock
    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wr(logic [5:0] a, logic [3:0] d);
        @(negedge clk_sys) {ramWrite, ramAddr, ramWriteData} = {1'b1, a, d};
        @(negedge clk_sys) ramWrite = 1'b0;
    endtask
    task automatic rd(logic [5:0] a, logic [3:0] exp);
        @(negedge clk_sys) ramAddr = a;
        @(negedge clk_sys) chk(16'(ramReadData), 16'(exp));
    endtask
    task automatic pulse(logic [6:0] e);
        @(negedge clk_sys) ev = e;
        @(negedge clk_sys) ev = 7'h00;
    endtask
    // Accept, then act as the routine: clear flag, wait for the return
    task automatic service(logic [5:0] a, logic [3:0] d, logic [15:0] v);
        for (int i = 0; i < 10 && irqAccept !== 1'b1; i++) cyc(1);
        chk(16'(irqAccept), 16'h0001);
        chk(vectorAddr, v);
        cyc(1);
        chk(16'({stackPush, globalIrqAllow}), 16'h0002);
        cyc(1);
        chk(16'({stackPush, vectorJump}), 16'h0003);
        wr(a, d);
        for (int i = 0; i < 30 && globalIrqAllow !== 1'b1; i++) cyc(1);
        chk(16'(globalIrqAllow), 16'h0001);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        #(25 * 4000);
        bad_count++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        cyc(10);
        reset_n = 1'b1;
        foreach (rows[k])
        begin
            wr(rows[k].a, rows[k].un);
            pulse(7'h01 << rows[k].e);
            rd(rows[k].a, rows[k].fl);
            chk(16'({irqRequest, irqAccept}), 16'h0002);
            wr(6'h00, 4'h9);
            service(rows[k].a, rows[k].rs, rows[k].v);
            wr(6'h00, 4'h8);
        end
        $display("vector table done");
        wr(6'h01, 4'h2);
        wr(6'h03, 4'h8);
        pulse(7'h09);
        wr(6'h00, 4'h9);
        service(6'h01, 4'hA, 16'h0006);
        service(6'h03, 4'hA, 16'h000C);
        wr(6'h00, 4'h8);
        $display("priority done");
        wr(6'h01, 4'h5);
        rd(6'h01, 4'h0);
        wr(6'h01, 4'hA);
        @(negedge clk_sys) {ramWrite, ramAddr, ramWriteData, ev} = {1'b1, 6'h02, 4'hA, 7'h02};
        @(negedge clk_sys) {ramWrite, ev} = 8'h00;
        rd(6'h02, 4'hB);
        wr(6'h02, 4'hA);
        $display("flag write done");
        pin0N = 1'b0;
        cyc(6);
        rd(6'h00, 4'hC);
        wr(6'h00, 4'h8);
        pin0N = 1'b1;
        cyc(6);
        rd(6'h00, 4'h8);
        wr(6'h26, 4'h2);
        pin2 = 1'b1;
        cyc(6);
        rd(6'h22, 4'hB);
        wr(6'h22, 4'hA);
        pin2 = 1'b0;
        cyc(6);
        rd(6'h22, 4'hA);
        $display("pins done");
        reset_n = 1'b0;
        cyc(2);
        reset_n = 1'b1;
        foreach (rst[k]) rd(rst[k][9:4], rst[k][3:0]);
        $display("reset done");
        end_of_test();
    end
endmodule
